/* dv/mftcc_assertions.sv */
// Checker for the timer's bus answers and its reset and pin outputs.
// Assumes it is bound to mftcc_top and sees only that module's ports.
`include "mftcc_regs.vh"
module mftcc_assertions
#(
  parameter N_OC = 6,
  parameter N_IC = 4
)
(
  // Clock, reset and bus.
  input            clock_i,
  input            resetn_i,
  input            hsel_i,
  input [7:0]      haddr_i,
  input [1:0]      htrans_i,
  input            hwrite_i,
  input            hready_i,
  input [31:0]     hrdata_o,
  input            hreadyout_o,
  input            hresp_o,
  // Pins and requests.
  input [N_OC-1:0] pulse_pattern_generator_i,
  input [N_OC-1:0] oc_out_o,
  input [N_OC-1:0] wave_o,
  input            irq_zero_o,
  input            irq_cclr_o,
  input [N_OC-1:0] irq_oc_o,
  input [N_IC-1:0] irq_ic_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Address phases as the slave accepts them.
  sequence s_rd;
    hsel_i && htrans_i[1] && !hwrite_i && hready_i;
  endsequence
  sequence s_wr;
    hsel_i && htrans_i[1] && hwrite_i && hready_i;
  endsequence
  a_ready_high: assert property (hreadyout_o) else $error("bus stalled");
  a_resp_okay: assert property (!hresp_o) else $error("error response");
  a_write_no_data: assert property (s_wr |=> hrdata_o == 32'h0)
    else $error("read data in write phase");
  a_idle_no_data: assert property (!(hsel_i && htrans_i[1] && hready_i) |=> hrdata_o == 32'h0)
    else $error("read data without read");
  a_count_upper: assert property (s_rd ##0 haddr_i == `MFTCC_OFF_COUNT |=> hrdata_o[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  // Each waveform pin shows last cycle's compare level or alternate source.
  a_wave_source: assert property (&(~(wave_o ^ $past(oc_out_o)) | ~(wave_o ^ $past(pulse_pattern_generator_i))))
    else $error("waveform source wrong");
  a_reset_out: assert property ($rose(resetn_i) |-> oc_out_o == '0 && wave_o == '0)
    else $error("pins not cleared by reset");
  a_reset_irq: assert property ($rose(resetn_i) |-> !irq_zero_o && !irq_cclr_o && irq_oc_o == '0 && irq_ic_o == '0)
    else $error("requests not cleared by reset");
endmodule
bind mftcc_top mftcc_assertions #(.N_OC(N_OC), .N_IC(N_IC)) chk_u (.*);

/* dv/mftcc_pins.sv */
// Model of the outside pins: capture inputs and alternate waveform sources.
// Assumes the bench asks for capture levels; delays are random, up to 3 cycles.
module mftcc_pins
(
  input wire logic        clock_i,
  input wire logic [3:0]  want_i,
  output logic     [3:0]  cap_o,
  output logic     [5:0]  pattern_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32'h94CB;
  // The alternate source changes every cycle, so a stale copy is caught.
  initial pattern_o = 6'h15;
  always @(posedge clock_i) pattern_o <= pattern_o + 6'h07;
  // Pins are unrelated to the count clock: land edges after a random delay.
  initial
  begin
    cap_o = 4'h0;
    forever
    begin
      @(posedge clock_i);
      if (want_i !== cap_o)
      begin
        repeat ($unsigned($random(seed)) % 4) @(posedge clock_i);
        cap_o <= want_i;
      end
    end
  end
endmodule

/* dv/mftcc_top_tb.sv */
// Self-checking bench of the timer: bus tasks, counter, compare and capture.
// Assumes one AHB-Lite master and a 200 MHz clock.
`include "mftcc_regs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module mftcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, resetn_i = 0, hsel_i = 0, hwrite_i = 0, hreadyout_o, hresp_o;
  logic [1:0]  htrans_i = 0;
  logic [7:0]  haddr_i = 0;
  logic [31:0] hwdata_i = 0, hrdata_o, q, c, v;
  logic [3:0]  want = 0, cap_pin_i, irq_ic_o;
  logic [5:0]  pattern, p, oc_out_o, wave_o, irq_oc_o;
  logic        irq_zero_o, irq_cclr_o;
  int          n_errors = 0, n_tests = 0;
  integer      seed = 32'h94CB;
  initial forever #2.5 clock_i = ~clock_i;
  mftcc_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cap_pin_i(cap_pin_i),
    .pulse_pattern_generator_i(pattern), .oc_out_o(oc_out_o), .wave_o(wave_o),
    .irq_zero_o(irq_zero_o), .irq_cclr_o(irq_cclr_o), .irq_oc_o(irq_oc_o),
    .irq_ic_o(irq_ic_o));
  mftcc_pins pins_u (.clock_i(clock_i), .want_i(want), .cap_o(cap_pin_i), .pattern_o(pattern));
  // One transfer, then an idle cycle so a read never follows its own write.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel_i <= 1'b1; haddr_i <= a; hwrite_i <= w; htrans_i <= 2'h2;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
    @(posedge clock_i);
  endtask
  // Ticks expected in the counted span for divider setting s, within two.
  function automatic logic near(input logic [31:0] n, input int s);
    return (n + 2 >= (259 >> s)) && (n <= (259 >> s) + 2);
  endfunction
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin repeat (40000) @(posedge clock_i); n_errors++; report_and_stop(); end
  initial
  begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    bus(8'hFC, 1, 32'hFFFFFFFF); bus(8'hFC, 0, 0); `CHK(q, 32'h0)
    bus(`MFTCC_OFF_CTRL, 0, 0); `CHK(q, 32'h20)
    bus(`MFTCC_OFF_COUNT, 0, 0); `CHK(q, 32'h0)
    for (int i = 0; i < 6; i++)
    begin
      bus(`MFTCC_OFF_OCCP0 + 4 * i, 1, i * 32'h1111 + 32'h7);
      bus(`MFTCC_OFF_OCCP0 + 4 * i, 0, 0); `CHK(q, i * 32'h1111 + 32'h7)
    end
    // Buffered compare-clear: loads only when the running count is zero.
    v = {16'h0, 1'b1, 15'($random(seed))};
    bus(`MFTCC_OFF_CTRL, 1, 32'h60); bus(`MFTCC_OFF_CCLR, 1, v);
    bus(`MFTCC_OFF_CCLR, 0, 0); `CHK(q, 32'hFFFF)
    bus(`MFTCC_OFF_CTRL, 1, 32'h40); repeat (4) @(posedge clock_i);
    bus(`MFTCC_OFF_CCLR, 0, 0); `CHK(q, v)
    for (int s = 0; s < 8; s++)
    begin
      bus(`MFTCC_OFF_CTRL, 1, 32'h20); bus(`MFTCC_OFF_COUNT, 1, 0);
      bus(`MFTCC_OFF_CTRL, 1, s); repeat (256) @(posedge clock_i);
      bus(`MFTCC_OFF_CTRL, 1, 32'h20 | s); bus(`MFTCC_OFF_COUNT, 0, 0);
      `CHK(near(q, s), 1'b1)
    end
    // Both modes stay within the compare-clear value.
    bus(`MFTCC_OFF_CCLR, 1, 5);
    for (int m = 0; m < 2; m++)
    begin
      bus(`MFTCC_OFF_CTRL, 1, 32'h180 | (m << 4));
      for (int k = 0; k < 6; k++)
      begin
        bus(`MFTCC_OFF_COUNT, 0, 0); `CHK(q <= 5, 1'b1)
      end
      `CHK({irq_zero_o, irq_cclr_o}, 2'b11)
    end
    bus(`MFTCC_OFF_CTRL, 1, 32'h1A0); bus(`MFTCC_OFF_STAT, 1, 3);
    bus(`MFTCC_OFF_OC_LEVEL, 1, 32'h2A); `CHK(oc_out_o, 6'h2A)
    `CHK({irq_zero_o, irq_cclr_o}, 2'b00)
    bus(`MFTCC_OFF_OCCP0, 1, 3); bus(`MFTCC_OFF_CCLR, 1, 32'hFFFF);
    bus(`MFTCC_OFF_COUNT, 1, 0); bus(`MFTCC_OFF_OC_CTRL, 1, 32'h10001);
    bus(`MFTCC_OFF_CTRL, 1, 0); repeat (8) @(posedge clock_i);
    `CHK(oc_out_o, 6'h2B)
    `CHK(irq_oc_o, 6'h01)
    // Capture on rising, falling, then both edges.
    for (int e = 1; e < 4; e++)
    begin
      bus(`MFTCC_OFF_IC_STAT, 1, 32'hF); bus(`MFTCC_OFF_IC_CTRL, 1, 32'h100 | e);
      want <= ~want; repeat (20) @(posedge clock_i);
      bus(`MFTCC_OFF_IC_STAT, 0, 0); `CHK(q, want[0] ? 32'h11 : 32'h01)
      `CHK(irq_ic_o, 4'h1)
      bus(`MFTCC_OFF_ICDAT0, 0, 0); c = q; bus(`MFTCC_OFF_COUNT, 0, 0);
      `CHK(c != 0 && c < q, 1'b1)
    end
    bus(`MFTCC_OFF_WAVE_SEL, 1, 32'h3F);
    @(negedge clock_i); p = pattern; @(negedge clock_i); `CHK(wave_o, p)
    report_and_stop();
  end
endmodule

/* verilog/mftcc_ic_ch.v */
// One input capture channel: pin synchroniser, edge detect and data latch.
// Assumes the pin is asynchronous and the tick marks the counter clock.
module mftcc_ic_ch
(
  // Clock and reset.
  input  wire        clock_i,
  input  wire        resetn_i,
  // Pin and configuration.
  input  wire        pin_i,
  input  wire [1:0]  edge_sel_i,
  // Counter side.
  input  wire        tick_i,
  input  wire [15:0] count_i,
  // Results.
  output reg         cap_o,
  output reg         rise_o,
  output reg  [15:0] data_o
);

  reg sync1_reg;  // First stage, read only by the second stage.
  reg sync2_reg;  // Second stage.
  reg sync3_reg;  // Third stage.
  reg level_reg;  // Last accepted level, sampled at count ticks.
  wire stable;
  wire rise;
  wire fall;

  // A level is accepted only when the second and third stage agree.
  assign stable = (sync2_reg == sync3_reg);
  assign rise   = stable & sync3_reg & ~level_reg;
  assign fall   = stable & ~sync3_reg & level_reg;

  // ----------------------------------------------------------------------
  // Synchroniser and capture
  // ----------------------------------------------------------------------
  // Edges are judged only on count ticks, so a slow prescaler filters glitches.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
      cap_o     <= 1'b0;
      rise_o    <= 1'b0;
      data_o    <= 16'h0000;
    end
    else
    begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      cap_o     <= 1'b0;
      if (tick_i && stable)                                        // R15
      begin
        level_reg <= sync3_reg;
        if ((rise && edge_sel_i[0]) || (fall && edge_sel_i[1]))  // R16
        begin
          data_o <= count_i;                                       // R14
          cap_o  <= 1'b1;                                          // R14
          rise_o <= rise;                                          // R16
        end
      end
    end
  end

endmodule

/* verilog/mftcc_oc_ch.v */
// One output compare channel: active compare value with optional buffer.
// Assumes the top supplies the count tick and a zero-load strobe.
module mftcc_oc_ch
(
  // Clock and reset.
  input  wire        clock_i,
  input  wire        resetn_i,
  // Software write of the compare value.
  input  wire        wr_i,
  input  wire [15:0] wdata_i,
  input  wire        buf_en_i,
  // Counter side.
  input  wire        tick_i,
  input  wire        zero_load_i,
  input  wire        run_i,
  input  wire [15:0] count_i,
  // Results.
  output wire        match_o,
  output wire [15:0] value_o
);

  reg [15:0] value_reg;   // Compare value in use.
  reg [15:0] buffer_reg;  // Staged value, moved over when the counter is zero.

  // ----------------------------------------------------------------------
  // Compare value update
  // ----------------------------------------------------------------------
  // Buffered writes wait for zero so a running waveform never sees a torn edge.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      value_reg  <= 16'hFFFF;
      buffer_reg <= 16'hFFFF;
    end
    else
    begin
      if (wr_i)
        buffer_reg <= wdata_i;
      if (wr_i && !buf_en_i)
        value_reg <= wdata_i;                         // R9
      else if (buf_en_i && zero_load_i)
        value_reg <= buffer_reg;                      // R9
    end
  end

  // A match only counts on a count tick of an enabled channel.
  assign match_o = run_i & tick_i & (count_i == value_reg);  // R9
  assign value_o = value_reg;

endmodule

/* verilog/mftcc_regs.vh */
// Register offsets, field positions and reset values of the timer block.
// Assumes a 32-bit AHB-Lite word map; every register is one aligned word.
`ifndef MFTCC_REGS_VH
`define MFTCC_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MFTCC_OFF_CTRL     8'h00
`define MFTCC_OFF_STAT     8'h04
`define MFTCC_OFF_COUNT    8'h08
`define MFTCC_OFF_CCLR     8'h0C
`define MFTCC_OFF_OC_CTRL  8'h10
`define MFTCC_OFF_OC_LEVEL 8'h14
`define MFTCC_OFF_OC_FLAG  8'h18
`define MFTCC_OFF_IC_CTRL  8'h1C
`define MFTCC_OFF_IC_STAT  8'h20
`define MFTCC_OFF_WAVE_SEL 8'h24
`define MFTCC_OFF_OCCP0    8'h40
`define MFTCC_OFF_ICDAT0   8'h60

// ----------------------------------------------------------------------
// Control and status register fields
// ----------------------------------------------------------------------
`define MFTCC_CTRL_CLK_LSB 0
`define MFTCC_CTRL_CLK_MSB 2
`define MFTCC_CTRL_SCLR    3
`define MFTCC_CTRL_MODE    4
`define MFTCC_CTRL_STOP    5
`define MFTCC_CTRL_BFE     6
`define MFTCC_CTRL_ZIE     7
`define MFTCC_CTRL_CIE     8
`define MFTCC_STAT_ZERO    0
`define MFTCC_STAT_CCLR    1
`define MFTCC_OCC_PAIR_LSB 12
`define MFTCC_OCC_IE_LSB   16
`define MFTCC_OCC_BUF_LSB  6
`define MFTCC_ICC_IE_LSB   8
`define MFTCC_ICS_EDGE_LSB 4

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define MFTCC_CCLR_RESET   16'hFFFF
`define MFTCC_COUNT_RESET  16'h0000
`define MFTCC_PRE_W        7

`endif

/* verilog/mftcc_top.v */
// Multifunction timer: free-running counter, six compares, four captures.
// Assumes one AHB-Lite master, single word transfers and asynchronous pins.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`include "mftcc_regs.vh"

// Function
// R1 - 16-bit counter, up or up-down mode
// R2 - Prescaler selects clock divided 1 to 128
// R3 - Compare-clear match raises interrupt request
// R4 - Counter zero raises zero-detect request
// R5 - Buffered compare-clear loads at counter zero
// R6 - Buffered update never stops the counter
// R7 - Reset, software clear, up-match zero counter
// R8 - Prescaler tick also clocks compare logic
// R9 - Compare match inverts output, raises request
// R10 - Six compare channels act independently
// R11 - Paired compares invert one shared pin
// R12 - Software presets compare output levels
// R13 - Six waveform outputs, source selectable
// R14 - Capture edge latches counter, raises request
// R15 - Capture edges sampled on count clock
// R16 - Rising, falling or both; edge reported
// R17 - Four independent capture channels
// R18 - Separate request per capture channel
// R19 - Up-down counts to compare, back to zero
// R20 - Flags sticky until cleared, gated by enable
module mftcc_top
#(
  parameter N_OC = 6,
  parameter N_IC = 4
)
(
  // Clock and reset.
  input  wire            clock_i,
  input  wire            resetn_i,
  // AHB-Lite slave.
  input  wire            hsel_i,
  input  wire [7:0]      haddr_i,
  input  wire [1:0]      htrans_i,
  input  wire            hwrite_i,
  input  wire [2:0]      hsize_i,
  input  wire [31:0]     hwdata_i,
  input  wire            hready_i,
  output reg  [31:0]     hrdata_o,
  output reg             hreadyout_o,
  output reg             hresp_o,
  // Pins.
  input  wire [N_IC-1:0] cap_pin_i,
  input  wire [N_OC-1:0] pulse_pattern_generator_i,
  output reg  [N_OC-1:0] oc_out_o,
  output reg  [N_OC-1:0] wave_o,
  // Interrupt requests.
  output reg             irq_zero_o,
  output reg             irq_cclr_o,
  output reg  [N_OC-1:0] irq_oc_o,
  output reg  [N_IC-1:0] irq_ic_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [7:0]              addr_reg;       // Data-phase address.
  reg                     wr_pend_reg;    // A write data phase is under way.
  reg  [31:0]             rdata_next;     // Read mux result.
  reg  [15:0]             ctrl_reg;       // Counter control fields.
  reg  [15:0]             count_reg;      // The free-running counter.
  reg                     down_reg;       // Up-down mode is counting down.
  reg  [15:0]             cclr_reg;       // Active compare-clear value.
  reg  [15:0]             cclr_buf_reg;   // Staged compare-clear value.
  reg  [`MFTCC_PRE_W-1:0] pre_reg;        // Prescaler.
  reg                     zero_flag_reg;  // Zero-detect flag.
  reg                     cclr_flag_reg;  // Compare-clear flag.
  reg  [21:0]             oc_ctrl_reg;    // Run, buffer, pair, irq enables.
  reg  [N_OC-1:0]         oc_flag_reg;    // Compare flags.
  reg  [2*N_IC+N_IC-1:0]  ic_ctrl_reg;    // Edge selects and irq enables.
  reg  [N_IC-1:0]         ic_flag_reg;    // Capture flags.
  reg  [N_IC-1:0]         ic_rise_reg;    // Polarity of the last capture.
  reg  [N_OC-1:0]         wave_sel_reg;   // 1 picks the pulse pattern source.
  reg  [N_OC-1:0]         oc_toggle;      // Per-pin inversion this cycle.
  reg  [`MFTCC_PRE_W-1:0] pre_mask;       // Divider mask for the tick.
  wire                    wr_en;          // Write data phase strobe.
  wire                    running;
  wire                    tick;           // One-cycle count clock enable.
  wire                    at_cclr;
  wire                    at_zero;
  wire                    zero_load;
  wire                    sclr;
  wire [N_OC-1:0]         oc_match;
  wire [16*N_OC-1:0]      oc_value;
  wire [N_IC-1:0]         ic_cap;
  wire [N_IC-1:0]         ic_rise;
  wire [16*N_IC-1:0]      ic_data;
  integer                 k, kp, ko, ki;   // One loop index per process.

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Zero wait states; read data are fetched at the address phase edge, so a
  // read right after a write to the same word still sees the old value.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      addr_reg    <= 8'h00;
      wr_pend_reg <= 1'b0;
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (hready_i)
      begin
        // Only NONSEQ or SEQ start a transfer; IDLE and BUSY are ignored.
        wr_pend_reg <= hsel_i & htrans_i[1] & hwrite_i;
        addr_reg    <= haddr_i;
        if (hsel_i && htrans_i[1] && !hwrite_i)
          hrdata_o <= rdata_next;
        else
          hrdata_o <= 32'h00000000;
      end
    end
  end

  assign wr_en = wr_pend_reg;

  // Read mux; unmapped words read as zero.
  always @*
  begin
    rdata_next = 32'h00000000;
    case (haddr_i)
      `MFTCC_OFF_CTRL:     rdata_next = {16'h0000, ctrl_reg};
      `MFTCC_OFF_STAT:     rdata_next = {30'h0, cclr_flag_reg, zero_flag_reg};
      `MFTCC_OFF_COUNT:    rdata_next = {16'h0000, count_reg};
      `MFTCC_OFF_CCLR:     rdata_next = {16'h0000, cclr_reg};
      `MFTCC_OFF_OC_CTRL:  rdata_next = {10'h000, oc_ctrl_reg};
      `MFTCC_OFF_OC_LEVEL: rdata_next = {26'h0, oc_out_o};
      `MFTCC_OFF_OC_FLAG:  rdata_next = {26'h0, oc_flag_reg};
      `MFTCC_OFF_IC_CTRL:  rdata_next = {20'h00000, ic_ctrl_reg};
      `MFTCC_OFF_IC_STAT:  rdata_next = {24'h000000, ic_rise_reg, ic_flag_reg};
      `MFTCC_OFF_WAVE_SEL: rdata_next = {26'h0, wave_sel_reg};
      default:
      begin
        for (k = 0; k < N_OC; k = k + 1)
          if (haddr_i == `MFTCC_OFF_OCCP0 + 4 * k)
            rdata_next = {16'h0000, oc_value[16*k +: 16]};
        for (k = 0; k < N_IC; k = k + 1)
          if (haddr_i == `MFTCC_OFF_ICDAT0 + 4 * k)
            rdata_next = {16'h0000, ic_data[16*k +: 16]};
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Software clear is a self-clearing bit; it reads as one only in the cycle after its write.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      ctrl_reg     <= 16'h0020;
      oc_ctrl_reg  <= 22'h000000;
      ic_ctrl_reg  <= 12'h000;
      wave_sel_reg <= 6'h00;
    end
    else
    begin
      ctrl_reg[`MFTCC_CTRL_SCLR] <= 1'b0;
      if (wr_en && addr_reg == `MFTCC_OFF_CTRL)
        ctrl_reg <= {7'h00, hwdata_i[8:0]};
      if (wr_en && addr_reg == `MFTCC_OFF_OC_CTRL)
        oc_ctrl_reg <= hwdata_i[21:0];
      if (wr_en && addr_reg == `MFTCC_OFF_IC_CTRL)
        ic_ctrl_reg <= hwdata_i[11:0];
      if (wr_en && addr_reg == `MFTCC_OFF_WAVE_SEL)
        wave_sel_reg <= hwdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  // The tick fires every 2^sel cycles; it also drives compare and capture.
  always @*
  begin
    pre_mask = 7'h00;
    case (ctrl_reg[`MFTCC_CTRL_CLK_MSB:`MFTCC_CTRL_CLK_LSB])
      3'h0:    pre_mask = 7'h00;
      3'h1:    pre_mask = 7'h01;
      3'h2:    pre_mask = 7'h03;
      3'h3:    pre_mask = 7'h07;
      3'h4:    pre_mask = 7'h0F;
      3'h5:    pre_mask = 7'h1F;
      3'h6:    pre_mask = 7'h3F;
      default: pre_mask = 7'h7F;
    endcase
  end

  assign running = ~ctrl_reg[`MFTCC_CTRL_STOP];
  assign tick    = running & ((pre_reg & pre_mask) == pre_mask);  // R2 R8
  assign sclr    = ctrl_reg[`MFTCC_CTRL_SCLR];
  assign at_cclr = (count_reg == cclr_reg);
  assign at_zero = (count_reg == 16'h0000);
  assign zero_load = tick & at_zero;

  always @(posedge clock_i)
  begin
    if (!resetn_i)
      pre_reg <= 7'h00;
    else if (!running || sclr)
      pre_reg <= 7'h00;
    else
      pre_reg <= pre_reg + 7'h01;                                 // R2
  end

  // ----------------------------------------------------------------------
  // Free-running counter and compare-clear
  // ----------------------------------------------------------------------
  // A buffered compare-clear write only touches the stage, so counting
  // carries on undisturbed while software updates the period.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      count_reg    <= `MFTCC_COUNT_RESET;                         // R7
      down_reg     <= 1'b0;
      cclr_reg     <= `MFTCC_CCLR_RESET;
      cclr_buf_reg <= `MFTCC_CCLR_RESET;
    end
    else
    begin
      if (wr_en && addr_reg == `MFTCC_OFF_CCLR)
      begin
        cclr_buf_reg <= hwdata_i[15:0];                           // R6
        if (!ctrl_reg[`MFTCC_CTRL_BFE])
          cclr_reg <= hwdata_i[15:0];
      end
      else if (ctrl_reg[`MFTCC_CTRL_BFE] && zero_load)
        cclr_reg <= cclr_buf_reg;                                 // R5
      if (sclr)
      begin
        count_reg <= 16'h0000;                                    // R7
        down_reg  <= 1'b0;
      end
      else if (wr_en && addr_reg == `MFTCC_OFF_COUNT)
        count_reg <= hwdata_i[15:0];
      else if (tick)
      begin
        if (!ctrl_reg[`MFTCC_CTRL_MODE])
        begin
          down_reg  <= 1'b0;
          count_reg <= at_cclr ? 16'h0000 : count_reg + 16'h0001; // R1 R7
        end
        else if (down_reg)
        begin
          count_reg <= count_reg - 16'h0001;                      // R19
          if (count_reg == 16'h0001)
            down_reg <= 1'b0;                                     // R19
        end
        else if (at_cclr)
        begin
          count_reg <= count_reg - 16'h0001;                      // R19
          down_reg  <= 1'b1;
        end
        else
          count_reg <= count_reg + 16'h0001;                      // R1
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter flags
  // ----------------------------------------------------------------------
  // A new event in the clearing cycle wins over the write-one clear.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      zero_flag_reg <= 1'b0;
      cclr_flag_reg <= 1'b0;
    end
    else
    begin
      if (zero_load)
        zero_flag_reg <= 1'b1;                                    // R4
      else if (wr_en && addr_reg == `MFTCC_OFF_STAT && hwdata_i[`MFTCC_STAT_ZERO])
        zero_flag_reg <= 1'b0;                                    // R20
      if (tick && at_cclr)
        cclr_flag_reg <= 1'b1;                                    // R3
      else if (wr_en && addr_reg == `MFTCC_OFF_STAT && hwdata_i[`MFTCC_STAT_CCLR])
        cclr_flag_reg <= 1'b0;                                    // R20
    end
  end

  // ----------------------------------------------------------------------
  // Output compare channels
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_OC; g = g + 1)
    begin : g_oc
      mftcc_oc_ch u_oc
      (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .wr_i        (wr_en && addr_reg == `MFTCC_OFF_OCCP0 + 4 * g),
        .wdata_i     (hwdata_i[15:0]),
        .buf_en_i    (oc_ctrl_reg[`MFTCC_OCC_BUF_LSB + g]),
        .tick_i      (tick),
        .zero_load_i (zero_load),
        .run_i       (oc_ctrl_reg[g]),
        .count_i     (count_reg),
        .match_o     (oc_match[g]),
        .value_o     (oc_value[16*g +: 16])
      );                                                          // R10
    end
  endgenerate

  // A paired odd channel steers the even pin instead of its own.
  always @*
  begin
    oc_toggle = oc_match;
    for (kp = 0; kp < N_OC / 2; kp = kp + 1)
      if (oc_ctrl_reg[`MFTCC_OCC_PAIR_LSB + kp])
      begin
        oc_toggle[2*kp]   = oc_match[2*kp] ^ oc_match[2*kp+1];     // R11
        oc_toggle[2*kp+1] = 1'b0;
      end
  end

  // ----------------------------------------------------------------------
  // Compare outputs, flags and waveform selection
  // ----------------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      oc_out_o    <= 6'h00;
      oc_flag_reg <= 6'h00;
      wave_o      <= 6'h00;
    end
    else
    begin
      if (wr_en && addr_reg == `MFTCC_OFF_OC_LEVEL)
        oc_out_o <= hwdata_i[5:0];                                // R12
      else
        oc_out_o <= oc_out_o ^ oc_toggle;                         // R9
      for (ko = 0; ko < N_OC; ko = ko + 1)
        if (oc_match[ko])
          oc_flag_reg[ko] <= 1'b1;                                // R9 R10
        else if (wr_en && addr_reg == `MFTCC_OFF_OC_FLAG && hwdata_i[ko])
          oc_flag_reg[ko] <= 1'b0;                                // R20
      wave_o <= (wave_sel_reg & pulse_pattern_generator_i)
              | (~wave_sel_reg & oc_out_o);                       // R13
    end
  end

  // ----------------------------------------------------------------------
  // Input capture channels
  // ----------------------------------------------------------------------
  generate
    for (g = 0; g < N_IC; g = g + 1)
    begin : g_ic
      mftcc_ic_ch u_ic
      (
        .clock_i    (clock_i),
        .resetn_i   (resetn_i),
        .pin_i      (cap_pin_i[g]),
        .edge_sel_i (ic_ctrl_reg[2*g +: 2]),
        .tick_i     (tick),
        .count_i    (count_reg),
        .cap_o      (ic_cap[g]),
        .rise_o     (ic_rise[g]),
        .data_o     (ic_data[16*g +: 16])
      );                                                          // R17
    end
  endgenerate

  // Each channel keeps its own flag and polarity indication.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      ic_flag_reg <= 4'h0;
      ic_rise_reg <= 4'h0;
    end
    else
    begin
      ic_rise_reg <= ic_rise;                                     // R16
      for (ki = 0; ki < N_IC; ki = ki + 1)
        if (ic_cap[ki])
          ic_flag_reg[ki] <= 1'b1;                                // R14 R18
        else if (wr_en && addr_reg == `MFTCC_OFF_IC_STAT && hwdata_i[ki])
          ic_flag_reg[ki] <= 1'b0;                                // R20
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------------
  // Requests follow their sticky flags one cycle later, gated by enables.
  always @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      irq_zero_o <= 1'b0;
      irq_cclr_o <= 1'b0;
      irq_oc_o   <= 6'h00;
      irq_ic_o   <= 4'h0;
    end
    else
    begin
      irq_zero_o <= zero_flag_reg & ctrl_reg[`MFTCC_CTRL_ZIE];    // R4 R20
      irq_cclr_o <= cclr_flag_reg & ctrl_reg[`MFTCC_CTRL_CIE];    // R3 R20
      irq_oc_o   <= oc_flag_reg & oc_ctrl_reg[21:16];             // R20
      irq_ic_o   <= ic_flag_reg & ic_ctrl_reg[11:8];              // R18 R20
    end
  end

endmodule
